//--- rtl/flash_ctl_pkg.sv
package flash_ctl_pkg;
	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [15:0] IDX_ERASE = 16'h0094;
	localparam logic [15:0] IDX_CTRL = 16'h00B2;
	localparam logic [15:0] IDX_PAGE = 16'h00B7;
	localparam logic [15:0] IDX_KEY = 16'h2702;
	localparam logic [15:0] IDX_IRQ_STAT = 16'h2710;
	localparam logic [15:0] IDX_IRQ_MASK = 16'h2711;
	localparam logic [15:0] ADDR_ERASE = 16'(IDX_ERASE * 4);
	localparam logic [15:0] ADDR_CTRL = 16'(IDX_CTRL * 4);
	localparam logic [15:0] ADDR_PAGE = 16'(IDX_PAGE * 4);
	localparam logic [15:0] ADDR_KEY = 16'(IDX_KEY * 4);
	localparam logic [15:0] ADDR_IRQ_STAT = 16'(IDX_IRQ_STAT * 4);
	localparam logic [15:0] ADDR_IRQ_MASK = 16'(IDX_IRQ_MASK * 4);
	// ==========================================================
	// Erase command key bytes
	localparam logic [7:0] KEY_PAGE_ERASE = 8'h55;
	localparam logic [7:0] KEY_MASS_ERASE = 8'hAA;
	// ==========================================================
	// Control register bit positions
	localparam int CTRL_PWE = 0;
	localparam int CTRL_MEEN = 1;
	localparam int CTRL_DEFER = 2;
	localparam int CTRL_PEND = 3;
	// Page select field position and range
	localparam int PAGE_LSB = 1;
	localparam int PAGE_MSB = 7;
	localparam logic [6:0] LAST_PAGE = 7'h3F;
	localparam logic [6:0] PAGE_RESET = 7'h00;
	// Key register fields
	localparam int KEY_RDE = 2;
	localparam int KEY_LSB = 4;
	localparam int KEY_MSB = 7;
	localparam logic [3:0] UNLOCK_VALUE = 4'h2;
	localparam logic [3:0] UNLOCK_RESET = 4'h0;
	// ==========================================================
	// Interrupt status bits
	localparam int IRQ_W = 3;
	localparam int EV_WRITE = 0;
	localparam int EV_DROP = 1;
	localparam int EV_ERASE = 2;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
	typedef enum logic {Q_EMPTY, Q_FULL} queue_t;
endpackage : flash_ctl_pkg

//--- rtl/flash_erase_write_control.sv
// Chosen here: the APB slave port.
module flash_erase_write_control (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclken,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic int_enabled,
	input wire logic debug_port_enabled,
	input wire logic security_lock,
	input wire logic ce_enable,
	input wire logic ce_busy,
	input wire logic flash_busy,
	input wire logic xmove_req,
	input wire logic [15:0] xmove_addr,
	input wire logic [7:0] xmove_data,
	output logic ram_wr_req,
	output logic [15:0] ram_wr_addr,
	output logic [7:0] ram_wr_data,
	output logic flash_wr_req,
	output logic [15:0] flash_wr_addr,
	output logic [7:0] flash_wr_data,
	output logic page_erase_req,
	output logic mass_erase_req,
	output logic [6:0] erase_page,
	output logic write_pending_flag,
	output logic irq
);
	import flash_ctl_pkg::*;

	// ==========================================================
	// State
	logic program_write_enable_r;
	logic mass_erase_enable_r;
	logic deferred_write_enable_r;
	logic [6:0] erase_page_select_r;
	logic page_fresh_r;
	logic [3:0] modify_unlock_key_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_stat_nxt;
	logic [IRQ_W-1:0] irq_mask_r;
	logic ce_busy_q_r;
	queue_t queue_r;
	logic [15:0] q_addr_r;
	logic [7:0] q_data_r;
	logic flash_wr_req_r;
	logic [15:0] flash_wr_addr_r;
	logic [7:0] flash_wr_data_r;
	logic ram_wr_req_r;
	logic [15:0] ram_wr_addr_r;
	logic [7:0] ram_wr_data_r;
	logic page_erase_req_r;
	logic mass_erase_req_r;
	logic [6:0] erase_page_r;

	// ==========================================================
	// APB decode
	wire logic acc = psel & penable & pclken;
	wire logic wr_en = acc & pwrite;
	wire logic hit_erase = paddr == ADDR_ERASE;
	wire logic hit_ctrl = paddr == ADDR_CTRL;
	wire logic hit_page = paddr == ADDR_PAGE;
	wire logic hit_key = paddr == ADDR_KEY;
	wire logic hit_stat = paddr == ADDR_IRQ_STAT;
	wire logic hit_mask = paddr == ADDR_IRQ_MASK;
	wire logic mapped = hit_erase | hit_ctrl | hit_page | hit_key
		| hit_stat | hit_mask;
	wire logic [7:0] wbyte = pwdata[7:0];

	// ==========================================================
	// Flash write path
	wire logic key_ok = modify_unlock_key_r == UNLOCK_VALUE;
	wire logic ce_fall = ce_busy_q_r & ~ce_busy;
	wire logic q_full = queue_r == Q_FULL;
	// Pending covers the gap before the array raises its busy
	wire logic pending = flash_busy | q_full | flash_wr_req_r;
	wire logic defer = deferred_write_enable_r & ce_enable;
	wire logic flash_move = pclken & xmove_req & program_write_enable_r;
	wire logic ram_move = pclken & xmove_req & ~program_write_enable_r;
	wire logic accept = flash_move & key_ok & ~pending;
	wire logic go_now = accept & ~defer;
	wire logic go_queue = accept & defer;
	wire logic drop = flash_move & ~accept;
	// Drain on busy fall, or at once if the engine is switched off
	wire logic drain = pclken & q_full & (ce_fall | ~ce_enable);

	// ==========================================================
	// Erase path
	wire logic erase_wr = wr_en & hit_erase;
	wire logic page_ok = erase_page_select_r <= LAST_PAGE;
	wire logic page_go = erase_wr & (wbyte == KEY_PAGE_ERASE) & key_ok
		& page_fresh_r & page_ok;
	wire logic mass_go = erase_wr & (wbyte == KEY_MASS_ERASE) & key_ok
		& mass_erase_enable_r & debug_port_enabled;
	wire logic pwe_wr = wr_en & hit_ctrl & ~int_enabled;

	// ==========================================================
	// Interrupt events; a new event wins over a clear
	wire logic [IRQ_W-1:0] events = {page_go | mass_go, drop,
		go_now | drain};
	wire logic [IRQ_W-1:0] stat_clr = (wr_en & hit_stat)
		? pwdata[IRQ_W-1:0] : IRQ_RESET;
	assign irq_stat_nxt = (irq_stat_r & ~stat_clr) | events;

	// ==========================================================
	// Read mux and outputs
	wire logic [7:0] ctrl_rd = {4'h0, pending, deferred_write_enable_r,
		1'b0, program_write_enable_r};
	wire logic [7:0] key_rd = {modify_unlock_key_r, 1'b0,
		~security_lock, 2'b00};
	assign prdata = !mapped ? 32'h0000_0000
		: hit_ctrl ? {24'h00_0000, ctrl_rd}
		: hit_key ? {24'h00_0000, key_rd}
		: hit_stat ? {29'h0000_0000, irq_stat_r}
		: hit_mask ? {29'h0000_0000, irq_mask_r}
		: 32'h0000_0000;
	assign pready = pclken;
	assign pslverr = psel & penable & ~mapped;
	assign write_pending_flag = pending;
	assign irq = |(irq_stat_r & irq_mask_r);
	assign flash_wr_req = flash_wr_req_r;
	assign flash_wr_addr = flash_wr_addr_r;
	assign flash_wr_data = flash_wr_data_r;
	assign ram_wr_req = ram_wr_req_r;
	assign ram_wr_addr = ram_wr_addr_r;
	assign ram_wr_data = ram_wr_data_r;
	assign page_erase_req = page_erase_req_r;
	assign mass_erase_req = mass_erase_req_r;
	assign erase_page = erase_page_r;

	// ==========================================================
	// Control register bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_write_enable_r <= 1'b0;
			mass_erase_enable_r <= 1'b0;
			deferred_write_enable_r <= 1'b0;
		end else if (pclken) begin
			if (pwe_wr)
				program_write_enable_r <= pwdata[CTRL_PWE];
			else if (flash_move)
				program_write_enable_r <= 1'b0;
			if (wr_en & hit_ctrl) begin
				mass_erase_enable_r <= pwdata[CTRL_MEEN];
				deferred_write_enable_r <= pwdata[CTRL_DEFER];
			end else if (mass_go)
				mass_erase_enable_r <= 1'b0;
		end
	end

	// Page select and unlock key
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_page_select_r <= PAGE_RESET;
			page_fresh_r <= 1'b0;
			modify_unlock_key_r <= UNLOCK_RESET;
		end else if (pclken) begin
			if (wr_en & hit_page) begin
				erase_page_select_r <= pwdata[PAGE_MSB:PAGE_LSB];
				page_fresh_r <= 1'b1;
			end else if (page_go)
				page_fresh_r <= 1'b0;
			if (wr_en & hit_key)
				modify_unlock_key_r <= pwdata[KEY_MSB:KEY_LSB];
		end
	end

	// Erase request pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_erase_req_r <= 1'b0;
			mass_erase_req_r <= 1'b0;
			erase_page_r <= PAGE_RESET;
		end else if (pclken) begin
			page_erase_req_r <= page_go;
			mass_erase_req_r <= mass_go;
			if (page_go)
				erase_page_r <= erase_page_select_r;
		end
	end

	// One-entry queue
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			queue_r <= Q_EMPTY;
			q_addr_r <= 16'h0000;
			q_data_r <= 8'h00;
			ce_busy_q_r <= 1'b0;
		end else if (pclken) begin
			ce_busy_q_r <= ce_busy;
			unique case (queue_r)
				Q_EMPTY: if (go_queue) begin
					queue_r <= Q_FULL;
					q_addr_r <= xmove_addr;
					q_data_r <= xmove_data;
				end
				Q_FULL: if (drain)
					queue_r <= Q_EMPTY;
			endcase
		end
	end

	// Flash and RAM write ports
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_wr_req_r <= 1'b0;
			flash_wr_addr_r <= 16'h0000;
			flash_wr_data_r <= 8'h00;
			ram_wr_req_r <= 1'b0;
			ram_wr_addr_r <= 16'h0000;
			ram_wr_data_r <= 8'h00;
		end else if (pclken) begin
			flash_wr_req_r <= go_now | drain;
			if (go_now) begin
				flash_wr_addr_r <= xmove_addr;
				flash_wr_data_r <= xmove_data;
			end else if (drain) begin
				flash_wr_addr_r <= q_addr_r;
				flash_wr_data_r <= q_data_r;
			end
			ram_wr_req_r <= ram_move;
			if (ram_move) begin
				ram_wr_addr_r <= xmove_addr;
				ram_wr_data_r <= xmove_data;
			end
		end
	end

	// Interrupt status and mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= IRQ_RESET;
			irq_mask_r <= IRQ_RESET;
		end else if (pclken) begin
			irq_stat_r <= irq_stat_nxt;
			if (wr_en & hit_mask)
				irq_mask_r <= pwdata[IRQ_W-1:0];
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_page_erase_go: assert property (page_go |=> page_erase_req
		&& erase_page == $past(erase_page_select_r))
		else $error("page erase not started");
	a_mass_erase_gate: assert property ($rose(mass_erase_req) |->
		$past(mass_erase_enable_r) && $past(debug_port_enabled))
		else $error("mass erase without enable");
	a_bad_key_ignored: assert property (erase_wr
		&& wbyte != KEY_PAGE_ERASE && wbyte != KEY_MASS_ERASE
		|=> !page_erase_req && !mass_erase_req && $stable(erase_page))
		else $error("bad erase key acted on");
	a_pending_drops: assert property (flash_move && pending
		&& !drain |=> !flash_wr_req && $stable(queue_r))
		else $error("write taken while pending");
	a_page_range: assert property (page_erase_req
		|-> erase_page <= LAST_PAGE)
		else $error("page out of range");
	a_queue_drain: assert property (q_full && pclken && ce_fall
		|=> flash_wr_req && flash_wr_data == $past(q_data_r) && !q_full)
		else $error("queued write not issued");
	a_direct_write: assert property (go_now
		|=> flash_wr_req && flash_wr_addr == $past(xmove_addr))
		else $error("direct write not issued");
	a_ram_route: assert property (xmove_req && pclken
		&& !program_write_enable_r && !drain
		|=> ram_wr_req && !flash_wr_req)
		else $error("ram move misrouted");
	a_pwe_autoclr: assert property (flash_move && !pwe_wr
		|=> !program_write_enable_r)
		else $error("write enable not cleared");
	a_pwe_blocked: assert property (int_enabled
		&& !program_write_enable_r |=> !program_write_enable_r)
		else $error("write enable set with interrupts on");
	a_readout_bit: assert property (acc && hit_key && !pwrite
		|-> prdata[KEY_RDE] == !security_lock)
		else $error("readout bit wrong");
	a_unlock_gate: assert property (!key_ok
		|=> !$rose(page_erase_req) && !$rose(mass_erase_req)
		&& !(flash_wr_req && $past(flash_move)))
		else $error("modify without unlock key");

	// Mass erase enable is used up by the erase it allows
	a_meen_used: assert property (mass_go
		|=> !mass_erase_enable_r)
		else $error("mass erase enable not cleared");

	// A page erase consumes the page select write
	a_fresh_used: assert property (page_go && !(wr_en && hit_page)
		|=> !page_fresh_r)
		else $error("page select reused");

	// A deferred write waits in the queue, not on the port
	a_queue_hold: assert property (go_queue
		|=> q_full && !flash_wr_req)
		else $error("deferred write not queued");

	// Pending shows while the request pulse stands
	a_pend_flag: assert property (flash_wr_req
		|-> write_pending_flag)
		else $error("pending low during write");

	// Software write of the enable bit lands when allowed
	a_pwe_write: assert property (pwe_wr
		|=> program_write_enable_r == $past(pwdata[CTRL_PWE]))
		else $error("write enable not written");

	// A dropped write sets its status bit even against a clear
	a_drop_status: assert property (drop
		|=> irq_stat_r[EV_DROP])
		else $error("drop status not set");

	// A one written to a status bit clears it when no event
	a_stat_clear: assert property (wr_en && hit_stat
		&& pwdata[EV_DROP] && !drop |=> !irq_stat_r[EV_DROP])
		else $error("status bit not cleared");

	// Clock enable low freezes state
	a_clken_freeze: assert property (!pclken
		|=> $stable(queue_r) && $stable(irq_stat_r)
		&& $stable(program_write_enable_r))
		else $error("state moved with clock enable low");

	// Unmapped access answers with an error and zero data
	a_unmapped_err: assert property (psel && penable && !mapped
		|-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
endmodule : flash_erase_write_control

//--- bench/flash_array_model.sv
// ==========================================================
// Flash array timing model: busy for a while after each byte
module flash_array_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic flash_wr_req,
	output logic flash_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// Busy rises the cycle after a write request, then counts down
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
		end else if (flash_wr_req) begin
			cnt <= 20;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
	end
	assign flash_busy = (cnt != 0);
endmodule : flash_array_model

//--- bench/flash_erase_write_control_test.sv
// ==========================================================
// Register and move-port bench
module flash_erase_write_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import flash_ctl_pkg::*;
	logic pclk = 0, presetn = 0, pclken = 1, psel = 0, penable = 0;
	logic pwrite = 0, int_enabled = 0, debug_port_enabled = 0;
	logic security_lock = 0, ce_enable = 0, ce_busy = 0, xmove_req = 0;
	logic [15:0] paddr = 0, xmove_addr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [7:0] xmove_data = 0;
	logic pready, pslverr, er, flash_busy, ram_wr_req, flash_wr_req;
	logic page_erase_req, mass_erase_req, write_pending_flag, irq;
	logic [15:0] ram_wr_addr, flash_wr_addr;
	logic [7:0] ram_wr_data, flash_wr_data;
	logic [6:0] erase_page;
	int failures = 0, n_checks = 0, pe = 0, me = 0, fw = 0, rw = 0, cyc = 0;
	always #4 pclk = ~pclk;
	flash_erase_write_control u_flash_erase_write_control (.pclk(pclk),
		.presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .int_enabled(int_enabled),
		.debug_port_enabled(debug_port_enabled),
		.security_lock(security_lock), .ce_enable(ce_enable),
		.ce_busy(ce_busy), .flash_busy(flash_busy), .xmove_req(xmove_req),
		.xmove_addr(xmove_addr), .xmove_data(xmove_data),
		.ram_wr_req(ram_wr_req), .ram_wr_addr(ram_wr_addr),
		.ram_wr_data(ram_wr_data), .flash_wr_req(flash_wr_req),
		.flash_wr_addr(flash_wr_addr), .flash_wr_data(flash_wr_data),
		.page_erase_req(page_erase_req), .mass_erase_req(mass_erase_req),
		.erase_page(erase_page), .write_pending_flag(write_pending_flag),
		.irq(irq));
	flash_array_model u_flash_array_model (.pclk(pclk), .presetn(presetn),
		.flash_wr_req(flash_wr_req), .flash_busy(flash_busy));
	// ==========================================================
	// Pulse counters and timeout
	always @(posedge pclk) begin
		pe <= pe + (page_erase_req === 1'b1);
		me <= me + (mass_erase_req === 1'b1);
		fw <= fw + (flash_wr_req === 1'b1);
		rw <= rw + (ram_wr_req === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			final_report();
		end
	end
	// ==========================================================
	// Tasks
	task final_report();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// APB transfer: setup, access until pready, then release
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task mv(input logic [15:0] a, input logic [7:0] d);
		@(posedge pclk);
		xmove_req <= 1;
		xmove_addr <= a;
		xmove_data <= d;
		@(posedge pclk);
		xmove_req <= 0;
		repeat (3) @(posedge pclk);
	endtask : mv
	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(0, ADDR_CTRL, 0);
		chk("ctrl", 0, rd);
		apb(0, ADDR_KEY, 0);
		chk("key", 32'h4, rd);
		security_lock <= 1;
		apb(0, ADDR_KEY, 0);
		chk("key", 0, rd);
		security_lock <= 0;
		apb(1, ADDR_PAGE, 32'h0A);
		apb(1, ADDR_ERASE, 32'h55);
		repeat (2) @(posedge pclk);
		chk("locked", 0, pe);
		apb(1, ADDR_KEY, 32'h20);
		apb(1, ADDR_PAGE, 32'h0A);
		apb(1, ADDR_ERASE, 32'h55);
		repeat (2) @(posedge pclk);
		chk("page", 1, pe);
		chk("epage", 5, erase_page);
		apb(1, ADDR_ERASE, 32'h55);
		repeat (2) @(posedge pclk);
		chk("stale", 1, pe);
		apb(1, ADDR_PAGE, 32'h7E);
		apb(1, ADDR_ERASE, 32'h55);
		repeat (2) @(posedge pclk);
		chk("epage", 63, erase_page);
		apb(1, ADDR_ERASE, 32'h12);
		apb(1, ADDR_ERASE, 32'hAA);
		repeat (2) @(posedge pclk);
		chk("other", 2, pe);
		chk("nomeen", 0, me);
		debug_port_enabled <= 1;
		apb(1, ADDR_CTRL, 32'h2);
		apb(1, ADDR_ERASE, 32'hAA);
		repeat (2) @(posedge pclk);
		chk("mass", 1, me);
		apb(1, ADDR_IRQ_MASK, 32'h2);
		mv(16'h0100, 8'h3C);
		chk("ram", 1, rw);
		chk("rdat", 8'h3C, ram_wr_data);
		chk("radr", 16'h0100, ram_wr_addr);
		apb(1, ADDR_CTRL, 32'h1);
		mv(16'h0200, 8'hA5);
		chk("flash", 1, fw);
		chk("fdat", 8'hA5, flash_wr_data);
		chk("fadr", 16'h0200, flash_wr_addr);
		apb(0, ADDR_CTRL, 0);
		chk("pwe", 32'h8, rd);
		apb(1, ADDR_CTRL, 32'h1);
		mv(16'h0201, 8'h5A);
		chk("drop", 1, fw);
		chk("irq", 1, irq);
		apb(1, ADDR_IRQ_STAT, 32'h2);
		@(posedge pclk);
		chk("irqclr", 0, irq);
		repeat (25) @(posedge pclk);
		int_enabled <= 1;
		apb(1, ADDR_CTRL, 32'h1);
		apb(0, ADDR_CTRL, 0);
		chk("inhib", 0, rd);
		int_enabled <= 0;
		ce_enable <= 1;
		ce_busy <= 1;
		apb(1, ADDR_CTRL, 32'h5);
		mv(16'h0202, 8'h77);
		chk("queued", 1, fw);
		chk("pend", 1, write_pending_flag);
		ce_busy <= 0;
		repeat (3) @(posedge pclk);
		chk("defer", 2, fw);
		chk("fdat", 8'h77, flash_wr_data);
		chk("fadr", 16'h0202, flash_wr_addr);
		apb(0, 16'h0004, 0);
		chk("slverr", 1, er);
		chk("unmap", 0, rd);
		final_report();
	end
endmodule : flash_erase_write_control_test
